/* i2m_master.sv */
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - reset or disable clears start/stop detected
// - stop on busy bus raises interrupt
// - driven data compared with line; mismatch flags collision
// - buffer write during sequence discarded, write collision
// - transmit: address byte, eight bits, ack received
// - receive: eight bits in, ack sent back
// - generator reloads from low seven baud bits
// - generator runs on buffer write, stops after ack
// - count down to zero, one step per two cycles
// - generator waits for clock high, then reloads
// - start: both high, count, then data low
// - start hold period then clear enable, interrupt
// - start collision: lines low, abort to idle
// - write during repeated start discarded, write collision
// - control requests ignored until sequence completes
// - repeated start: clock low, release data, clock
// - data low one period, then clear, interrupt
// - repeated start collision on data or clock
// - repeated start ignored while another event runs
// - ack stored, interrupt at ninth clock end
module i2m_master (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // control
  input wire logic port_enable_bit,
  input wire logic [3:0] port_mode_select,
  input wire logic [i2m_pkg::DATA_W-1:0] slave_addr_baud_reg,
  input wire logic port_irq_enable,
  input wire logic start_req,
  input wire logic rstart_req,
  input wire logic rx_req,
  input wire logic ack_data_bit,
  // transmit buffer
  input wire logic tx_write,
  input wire logic [i2m_pkg::DATA_W-1:0] tx_data,
  // received bytes
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [i2m_pkg::DATA_W-1:0] rx_data,
  // flag clears
  input wire logic clr_irq,
  input wire logic clr_bcl,
  input wire logic clr_wr_coll,
  // status
  output logic start_detected,
  output logic stop_detected,
  output logic bus_collision_flag,
  output logic write_collision_flag,
  output logic port_interrupt_flag,
  output logic ack_received_status,
  output logic start_enable_bit,
  output logic repeated_start_enable_bit,
  output logic master_busy,
  // bus lines
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  import i2m_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  i2m_state_t state_q;
  logic scl_m_q;
  logic scl_s;
  logic sda_m_q;
  logic sda_s;
  logic sda_p_q;
  logic master_on;
  logic start_cond;
  logic stop_cond;
  logic brg_load_q;
  logic [3:0] bit_q;
  logic [DATA_W-1:0] shift_q;
  logic rx_mode_q;
  logic ev_irq_q;
  logic ev_bcl_q;
  logic ev_wr_coll_q;
  logic ev_push_q;
  logic fifo_in_ready;
  logic scl_oe_d;
  logic sda_oe_d;
  i2m_brg_if brg_bus ();

  // whether to pull the bus low while this bit is on the wire
  function automatic logic pull_low(input logic rx, input logic [3:0] b,
                                    input logic [DATA_W-1:0] sh, input logic ack);
    if (b == ACK_BIT)
    begin
      pull_low = rx && (ack == ACK_LEVEL);
    end
    else
    begin
      pull_low = !rx && !sh[DATA_W-1];
    end
  endfunction

  // whether this bit is ours to drive, so a mismatch means lost arbitration
  function automatic logic we_drive(input logic rx, input logic [3:0] b);
    we_drive = (b == ACK_BIT) ? rx : !rx;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pins cross in from the bus: two flops before any use
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      scl_m_q <= 1'h1;
      scl_s <= 1'h1;
      sda_m_q <= 1'h1;
      sda_s <= 1'h1;
      sda_p_q <= 1'h1;
    end
    else
    begin
      scl_m_q <= scl_i;
      scl_s <= scl_m_q;
      sda_m_q <= sda_i;
      sda_s <= sda_m_q;
      sda_p_q <= sda_s;
    end
  end

  // open drain: only ever pull low, the line value itself is never driven high
  always_ff @(posedge clk_sys)
  begin
    scl_o <= 1'h0;
    sda_o <= 1'h0;
  end

  assign master_on = port_enable_bit && (port_mode_select == MODE_MASTER);
  assign start_cond = scl_s && sda_p_q && !sda_s;
  assign stop_cond = scl_s && !sda_p_q && sda_s;
  assign brg_bus.load = brg_load_q;
  assign brg_bus.reload = slave_addr_baud_reg[RELOAD_W-1:0];

  //////////////////////////////////////////////////////////////////////////////
  // bus monitor, also watches other masters
  always_ff @(posedge clk_sys)
  begin
    if (reset || !port_enable_bit)
    begin
      start_detected <= 1'h0;
      stop_detected <= 1'h0;
    end
    else if (start_cond)
    begin
      start_detected <= 1'h1;
      stop_detected <= 1'h0;
    end
    else if (stop_cond)
    begin
      stop_detected <= 1'h1;
      start_detected <= 1'h0;
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      port_interrupt_flag <= 1'h0;
      bus_collision_flag <= 1'h0;
      write_collision_flag <= 1'h0;
    end
    else
    begin
      port_interrupt_flag <= ev_irq_q || (stop_cond && start_detected && port_irq_enable)
                             || (port_interrupt_flag && !clr_irq);
      bus_collision_flag <= ev_bcl_q || (bus_collision_flag && !clr_bcl);
      write_collision_flag <= ev_wr_coll_q || (write_collision_flag && !clr_wr_coll);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      master_busy <= 1'h0;
      scl_oe <= 1'h0;
      sda_oe <= 1'h0;
    end
    else
    begin
      master_busy <= state_q != ST_IDLE;
      scl_oe <= scl_oe_d;
      sda_oe <= sda_oe_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clk_sys)
  begin
    if (reset || !master_on)
    begin
      state_q <= ST_IDLE;
      scl_oe_d <= 1'h0;
      sda_oe_d <= 1'h0;
      start_enable_bit <= 1'h0;
      repeated_start_enable_bit <= 1'h0;
      brg_load_q <= 1'h0;
      ev_irq_q <= 1'h0;
      ev_bcl_q <= 1'h0;
      ev_wr_coll_q <= 1'h0;
      ev_push_q <= 1'h0;
      bit_q <= FIRST_BIT;
      shift_q <= '0;
      rx_mode_q <= 1'h0;
      ack_received_status <= 1'h0;
    end
    else
    begin
      brg_load_q <= 1'h0;
      ev_irq_q <= 1'h0;
      ev_bcl_q <= 1'h0;
      ev_push_q <= 1'h0;
      // no queueing: a buffer write during any sequence is dropped
      ev_wr_coll_q <= tx_write && (state_q != ST_IDLE);
      case (state_q)
        ST_IDLE:
        begin
          // requests only act from idle, so none is held over
          if (start_req)
          begin
            if (scl_s && sda_s)
            begin
              start_enable_bit <= 1'h1;
              brg_load_q <= 1'h1;
              state_q <= ST_START_WAIT;
            end
            else
            begin
              ev_bcl_q <= 1'h1;
            end
          end
          else if (rstart_req)
          begin
            repeated_start_enable_bit <= 1'h1;
            scl_oe_d <= 1'h1;
            state_q <= ST_RS_PULL;
          end
          else if (tx_write)
          begin
            shift_q <= tx_data;
            rx_mode_q <= 1'h0;
            bit_q <= FIRST_BIT;
            scl_oe_d <= 1'h1;
            state_q <= ST_BIT_SETUP;
          end
          else if (rx_req && fifo_in_ready && !ev_push_q)
          begin
            rx_mode_q <= 1'h1;
            bit_q <= FIRST_BIT;
            scl_oe_d <= 1'h1;
            state_q <= ST_BIT_SETUP;
          end
        end
        ST_START_WAIT:
        begin
          if (!scl_s || !sda_s)
          begin
            state_q <= ST_ABORT;
          end
          else if (brg_bus.timeout)
          begin
            sda_oe_d <= 1'h1;
            brg_load_q <= 1'h1;
            state_q <= ST_START_HOLD;
          end
        end
        ST_START_HOLD:
        begin
          if (brg_bus.timeout)
          begin
            start_enable_bit <= 1'h0;
            ev_irq_q <= 1'h1;
            state_q <= ST_IDLE;
          end
        end
        ST_RS_PULL:
        begin
          if (!scl_s)
          begin
            brg_load_q <= 1'h1;
            sda_oe_d <= 1'h0;
            state_q <= ST_RS_SDA_HI;
          end
        end
        ST_RS_SDA_HI:
        begin
          if (brg_bus.timeout)
          begin
            if (sda_s)
            begin
              scl_oe_d <= 1'h0;
              state_q <= ST_RS_SCL_RISE;
            end
            else
            begin
              state_q <= ST_ABORT;
            end
          end
        end
        ST_RS_SCL_RISE:
        begin
          if (scl_s && !sda_s)
          begin
            state_q <= ST_ABORT;
          end
          else if (scl_s)
          begin
            brg_load_q <= 1'h1;
            state_q <= ST_RS_BOTH_HI;
          end
        end
        ST_RS_BOTH_HI:
        begin
          if (!scl_s || !sda_s)
          begin
            state_q <= ST_ABORT;
          end
          else if (brg_bus.timeout)
          begin
            sda_oe_d <= 1'h1;
            brg_load_q <= 1'h1;
            state_q <= ST_RS_SDA_LOW;
          end
        end
        ST_RS_SDA_LOW:
        begin
          if (brg_bus.timeout)
          begin
            repeated_start_enable_bit <= 1'h0;
            ev_irq_q <= 1'h1;
            state_q <= ST_IDLE;
          end
        end
        ST_BIT_SETUP:
        begin
          // data moves only once the clock is already held low
          sda_oe_d <= pull_low(rx_mode_q, bit_q, shift_q, ack_data_bit);
          brg_load_q <= 1'h1;
          state_q <= ST_BIT_LOW;
        end
        ST_BIT_LOW:
        begin
          if (brg_bus.timeout)
          begin
            scl_oe_d <= 1'h0;
            state_q <= ST_BIT_RISE;
          end
        end
        ST_BIT_RISE:
        begin
          // a slave stretching the clock holds the count here
          if (scl_s)
          begin
            brg_load_q <= 1'h1;
            state_q <= ST_BIT_HIGH;
          end
        end
        ST_BIT_HIGH:
        begin
          if (we_drive(rx_mode_q, bit_q) && !sda_oe_d && !sda_s)
          begin
            state_q <= ST_ABORT;
          end
          else if (brg_bus.timeout)
          begin
            scl_oe_d <= 1'h1;
            if (bit_q == ACK_BIT)
            begin
              if (!rx_mode_q)
              begin
                ack_received_status <= sda_s;
              end
              ev_push_q <= rx_mode_q;
              ev_irq_q <= 1'h1;
              state_q <= ST_IDLE;
            end
            else
            begin
              shift_q <= {shift_q[DATA_W-2:0], sda_s};
              bit_q <= bit_q + 4'h1;
              state_q <= ST_BIT_SETUP;
            end
          end
        end
        ST_ABORT:
        begin
          // lost the bus: let go of both lines and fall back to idle
          scl_oe_d <= 1'h0;
          sda_oe_d <= 1'h0;
          start_enable_bit <= 1'h0;
          repeated_start_enable_bit <= 1'h0;
          ev_bcl_q <= 1'h1;
          state_q <= ST_IDLE;
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  i2m_brg #(
    .STEP_CYCLES(BRG_STEP_CYCLES)
  ) u_brg (
    .clk_sys(clk_sys),
    .reset(reset),
    .brg(brg_bus.gen)
  );

  // a full queue refuses new receive requests until software drains it
  i2m_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(ev_push_q),
    .in_ready(fifo_in_ready),
    .in_data(shift_q),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );
endmodule
`default_nettype wire

/* i2m_pkg.sv */
`default_nettype none
package i2m_pkg;
  // bus timing: clk_sys is the oscillator, count steps once every two clk_sys cycles
  localparam int CLK_PERIOD_NS = 100;
  localparam int BRG_STEP_NS = 200;
  localparam int BRG_STEP_CYCLES = (BRG_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RELOAD_W = 7;
  localparam int DATA_W = 8;
  localparam int RX_FIFO_DEPTH = 8;
  localparam logic [3:0] FIRST_BIT = 4'h0;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [3:0] MODE_MASTER = 4'h8;
  localparam logic ACK_LEVEL = 1'h0;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_START_WAIT = 4'h1,
    ST_START_HOLD = 4'h2,
    ST_RS_PULL = 4'h3,
    ST_RS_SDA_HI = 4'h4,
    ST_RS_SCL_RISE = 4'h5,
    ST_RS_BOTH_HI = 4'h6,
    ST_RS_SDA_LOW = 4'h7,
    ST_BIT_SETUP = 4'h8,
    ST_BIT_LOW = 4'h9,
    ST_BIT_RISE = 4'hA,
    ST_BIT_HIGH = 4'hB,
    ST_ABORT = 4'hC
  } i2m_state_t;
endpackage
`default_nettype wire

/* i2m_brg_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface i2m_brg_if;
  import i2m_pkg::*;
  logic load;
  logic [RELOAD_W-1:0] reload;
  logic timeout;
  modport ctl (output load, output reload, input timeout);
  modport gen (input load, input reload, output timeout);
endinterface
`default_nettype wire

/* i2m_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module i2m_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side, read data registered
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_bad_depth
      $error("fifo depth must be a power of two, at least 2");
    end
  endgenerate
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic push;
  logic pop;
  assign in_ready = cnt_q != FULL;
  assign push = in_valid && in_ready;
  assign pop = (cnt_q != '0) && (!out_valid || out_ready);
  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      out_valid <= 1'h0;
      out_data <= '0;
    end
    else
    begin
      wr_q <= push ? wr_q + 1'h1 : wr_q;
      rd_q <= pop ? rd_q + 1'h1 : rd_q;
      cnt_q <= cnt_q + CW'(push) - CW'(pop);
      if (pop)
      begin
        out_data <= mem_q[rd_q];
        out_valid <= 1'h1;
      end
      else if (out_ready)
      begin
        out_valid <= 1'h0;
      end
    end
  end
endmodule
`default_nettype wire

/* i2m_brg.sv */
`timescale 1ns/1ps
`default_nettype none
module i2m_brg #(
  parameter int STEP_CYCLES = 2
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // control from the sequencer
  i2m_brg_if.gen brg
);
  import i2m_pkg::*;
  localparam int SW = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;
  generate
    if (STEP_CYCLES < 1)
    begin : g_bad_step
      $error("step divider must be at least 1");
    end
  endgenerate
  logic [SW-1:0] div_q;
  logic step;
  logic [RELOAD_W-1:0] cnt_q;
  logic active_q;
  assign step = div_q == SW'(STEP_CYCLES - 1);
  always_ff @(posedge clk_sys)
  begin
    if (reset || step)
    begin
      div_q <= '0;
    end
    else
    begin
      div_q <= div_q + 1'h1;
    end
  end
  // counts down to zero, then idles until the next reload
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cnt_q <= '0;
      active_q <= 1'h0;
      brg.timeout <= 1'h0;
    end
    else
    begin
      brg.timeout <= 1'h0;
      if (brg.load)
      begin
        cnt_q <= brg.reload;
        active_q <= 1'h1;
      end
      else if (active_q && step)
      begin
        if (cnt_q == '0)
        begin
          active_q <= 1'h0;
          brg.timeout <= 1'h1;
        end
        else
        begin
          cnt_q <= cnt_q - 1'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* i2m_master_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module i2m_master_properties (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // control
  input wire logic port_enable_bit,
  input wire logic tx_write,
  input wire logic clr_bcl,
  // status
  input wire logic start_detected,
  input wire logic stop_detected,
  input wire logic start_enable_bit,
  input wire logic repeated_start_enable_bit,
  input wire logic write_collision_flag,
  input wire logic bus_collision_flag,
  input wire logic port_interrupt_flag,
  input wire logic ack_received_status,
  input wire logic rx_valid,
  // bus lines
  input wire logic scl_o,
  input wire logic sda_o,
  input wire logic scl_oe,
  input wire logic sda_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic seq_run;
  assign seq_run = start_enable_bit || repeated_start_enable_bit;
  //////////////////////////////////////////////////////////////////////////////
  drive_low_only_a: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("bus line driven high");
  reset_quiet_a: assert property ($fell(reset) |-> !scl_oe && !sda_oe
    && !bus_collision_flag && !port_interrupt_flag && !start_detected && !stop_detected)
    else $error("state left over after reset");
  disable_clears_a: assert property (!port_enable_bit |=> !start_detected && !stop_detected)
    else $error("detect bits kept while disabled");
  wr_coll_busy_a: assert property (tx_write && seq_run && port_enable_bit
    |-> ##2 write_collision_flag)
    else $error("write during sequence not flagged");
  // data may only fall with the clock released while a start kind runs
  start_edge_a: assert property ($rose(sda_oe) && !scl_oe |-> seq_run)
    else $error("data pulled low under high clock outside start");
  start_done_a: assert property ($fell(start_enable_bit) && port_enable_bit
    ##2 !bus_collision_flag |-> port_interrupt_flag && sda_oe)
    else $error("start end without interrupt or held data");
  rstart_done_a: assert property ($fell(repeated_start_enable_bit) && port_enable_bit
    ##2 !bus_collision_flag |-> port_interrupt_flag && sda_oe)
    else $error("repeated start end without interrupt or held data");
  bcl_sticky_a: assert property (bus_collision_flag && !clr_bcl && port_enable_bit
    |=> bus_collision_flag)
    else $error("collision flag lost");
  ack_irq_a: assert property ($changed(ack_received_status) && port_enable_bit
    |-> ##[0:1] port_interrupt_flag)
    else $error("ack stored without interrupt");
  cover property ($fell(start_enable_bit) ##2 !bus_collision_flag);
  cover property ($rose(bus_collision_flag));
  cover property ($rose(rx_valid));
endmodule
bind i2m_master i2m_master_properties u_props (.clk_sys, .reset, .port_enable_bit, .tx_write,
  .clr_bcl, .start_detected, .stop_detected, .start_enable_bit, .repeated_start_enable_bit,
  .write_collision_flag, .bus_collision_flag, .port_interrupt_flag, .ack_received_status,
  .rx_valid, .scl_o, .sda_o, .scl_oe, .sda_oe);
`default_nettype wire

/* i2m_bus_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module i2m_bus_partner (
  // clock
  input wire logic clk_sys,
  // wire levels
  input wire logic scl,
  input wire logic sda,
  // test knobs
  input wire logic nack,
  input wire logic hold_scl,
  input wire logic pull_sda,
  // pull enables and what was seen
  output logic scl_oe_s,
  output logic sda_oe_s,
  output logic [7:0] got,
  output logic ack_seen
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic first = 1'b1;
  logic rd = 1'b0;
  logic sda_d = 1'b0;
  logic [3:0] cnt = 4'h0;
  logic [7:0] sh = 8'h00;
  logic [7:0] rd_byte = 8'h30;
  // only ever pulls low; release leaves the pull-up in charge
  assign scl_oe_s = hold_scl;
  assign sda_oe_s = sda_d || pull_sda;
  always @(posedge clk_sys)
  begin
    scl_q <= scl;
    sda_q <= sda;
    if (scl_q && scl && sda_q && !sda)
    begin
      cnt <= 4'h0;
      first <= 1'b1;
    end
    else if (!scl_q && scl)
    begin
      sh <= {sh[6:0], sda};
      cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
      if (cnt == 4'h7)
        got <= {sh[6:0], sda};
      if (cnt == 4'h7 && first)
        rd <= sda;
      if (cnt == 4'h8)
      begin
        ack_seen <= sda;
        first <= 1'b0;
        if (rd && !first)
          rd_byte <= rd_byte + 8'h01;
      end
    end
    // change data only while the clock is low
    else if (scl_q && !scl)
      sda_d <= (cnt == 4'h8) ? ((first || !rd) && !nack)
        : (rd && !first && !rd_byte[4'h7 - cnt]);
  end
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import i2m_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic en = 1'b1;
  logic ackd = 1'b0;
  logic start_req = 1'b0;
  logic rstart_req = 1'b0;
  logic rx_req = 1'b0;
  logic tx_write = 1'b0;
  logic rx_ready = 1'b0;
  logic clr_irq = 1'b0;
  logic clr_bcl = 1'b0;
  logic clr_wr_coll = 1'b0;
  logic [3:0] mode = MODE_MASTER;
  logic irq_en = 1'b1;
  logic nack = 1'b0;
  logic hold_scl = 1'b0;
  logic pull_sda = 1'b0;
  logic [DATA_W-1:0] tx_data = 8'h00;
  logic [DATA_W-1:0] rx_data, got;
  logic rx_valid, sdet, pdet, bcl, wr_coll, irq, ack, start_en, rstart_en, busy, ack_seen;
  logic scl_o, scl_oe, sda_o, sda_oe, scl_oe_s, sda_oe_s;
  wire scl = !(scl_oe || scl_oe_s);
  wire sda = !(sda_oe || sda_oe_s);
  int error_cnt = 0;
  int checked = 0;
  always #50 clk_sys = ~clk_sys;
  //////////////////////////////////////////////////////////////////////////////
  i2m_master dut (.clk_sys, .reset, .port_enable_bit(en), .port_mode_select(mode),
    .slave_addr_baud_reg(8'h83), .port_irq_enable(irq_en), .start_req, .rstart_req, .rx_req,
    .ack_data_bit(ackd), .tx_write, .tx_data, .rx_valid, .rx_ready, .rx_data, .clr_irq,
    .clr_bcl, .clr_wr_coll, .start_detected(sdet), .stop_detected(pdet),
    .bus_collision_flag(bcl), .write_collision_flag(wr_coll), .port_interrupt_flag(irq),
    .ack_received_status(ack), .start_enable_bit(start_en),
    .repeated_start_enable_bit(rstart_en), .master_busy(busy), .scl_i(scl), .scl_o,
    .scl_oe, .sda_i(sda), .sda_o, .sda_oe);
  i2m_bus_partner partner (.clk_sys, .scl, .sda, .nack, .hold_scl, .pull_sda, .scl_oe_s,
    .sda_oe_s, .got, .ack_seen);
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (error_cnt == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp1(input logic g, input logic e);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // inputs always move 10 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #10;
  endtask
  task automatic pulse(input int k);
    case (k)
      0: start_req = 1'b1;
      1: rstart_req = 1'b1;
      2: rx_req = 1'b1;
      3: tx_write = 1'b1;
      default: {clr_irq, clr_bcl, clr_wr_coll} = 3'h7;
    endcase
    tick(1);
    {start_req, rstart_req, rx_req, tx_write} = 4'h0;
    {clr_irq, clr_bcl, clr_wr_coll} = 3'h0;
    tick(1);
  endtask
  // k 0: sequencer idle, k 1: received word offered
  task automatic wait_on(input int k, input int lim);
    int n;
    n = 0;
    tick(3);
    while ((k == 0 ? (busy || start_en || rstart_en) !== 1'b0 : rx_valid !== 1'b1) && n < lim)
    begin
      tick(1);
      n++;
    end
    if (n >= lim)
    begin
      error_cnt++;
      end_of_test();
    end
    tick(2);
  endtask
  task automatic send(input logic [7:0] b);
    tx_data = b;
    pulse(3);
    wait_on(0, 400);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_start();
    cmp1(sdet, 1'b0);
    cmp1(pdet, 1'b0);
    pulse(0);
    tx_data = 8'h55;
    pulse(3);
    pulse(1);
    // a wide reload would overrun this bound
    wait_on(0, 40);
    cmp1(wr_coll, 1'b1);
    cmp1(start_en, 1'b0);
    cmp1(sdet, 1'b1);
    cmp1(irq, 1'b1);
    cmp1(sda_oe, 1'b1);
    cmp1(scl_oe, 1'b0);
    cmp1(bcl, 1'b0);
  endtask
  task automatic t_tx();
    pulse(4);
    send(8'hA4);
    cmp8(got, 8'hA4);
    cmp1(ack, 1'b0);
    cmp1(irq, 1'b1);
    cmp1(scl_oe, 1'b1);
    nack = 1'b1;
    tx_data = 8'h3C;
    // a slave stretching the first low phase must not cost a bit
    hold_scl = 1'b1;
    pulse(3);
    tick(40);
    hold_scl = 1'b0;
    wait_on(0, 400);
    cmp8(got, 8'h3C);
    cmp1(ack, 1'b1);
    nack = 1'b0;
  endtask
  task automatic t_rstart();
    pulse(4);
    pulse(1);
    wait_on(0, 100);
    cmp1(rstart_en, 1'b0);
    cmp1(irq, 1'b1);
    cmp1(sda_oe, 1'b1);
    cmp1(scl_oe, 1'b0);
    cmp1(bcl, 1'b0);
  endtask
  task automatic t_bus();
    int i;
    en = 1'b0;
    tick(2);
    cmp1(sdet, 1'b0);
    cmp1(pdet, 1'b0);
    en = 1'b1;
    // any mode but master leaves requests without effect
    mode = 4'h0;
    tick(4);
    pulse(0);
    cmp1(busy, 1'b0);
    mode = MODE_MASTER;
    pulse(4);
    hold_scl = 1'b1;
    tick(3);
    pulse(0);
    wait_on(0, 40);
    cmp1(bcl, 1'b1);
    cmp1(sda_oe, 1'b0);
    hold_scl = 1'b0;
    pulse(4);
    cmp1(bcl, 1'b0);
    // first pass with the interrupt off, second with it on
    for (i = 0; i < 2; i++)
    begin
      irq_en = (i == 1);
      pull_sda = 1'b1;
      tick(4);
      pull_sda = 1'b0;
      tick(4);
      cmp1(pdet, 1'b1);
      cmp1(irq, irq_en);
    end
  endtask
  task automatic t_rx();
    int i;
    pulse(4);
    pulse(0);
    wait_on(0, 40);
    send(8'hA5);
    cmp1(ack, 1'b0);
    for (i = 0; i <= RX_FIFO_DEPTH; i++)
    begin
      ackd = (i == RX_FIFO_DEPTH);
      pulse(2);
      wait_on(0, 400);
      cmp1(ack_seen, i == RX_FIFO_DEPTH);
    end
    // fifo and output word full: this request must be refused
    pulse(2);
    cmp1(busy, 1'b0);
    for (i = 0; i <= RX_FIFO_DEPTH; i++)
    begin
      wait_on(1, 10);
      cmp8(rx_data, 8'h30 + 8'(i));
      rx_ready = 1'b1;
      tick(1);
      rx_ready = 1'b0;
      tick(1);
    end
    cmp1(rx_valid, 1'b0);
  endtask
  initial
  begin
    repeat (20) @(posedge clk_sys);
    #10;
    reset = 1'b0;
    tick(3);
    t_start();
    t_tx();
    t_rstart();
    t_bus();
    t_rx();
    end_of_test();
  end
endmodule
`default_nettype wire
